// ### verilog/can_bit_timing_map.svh
// register offsets, field positions and reset values of the bit-timing engine
// assumes a 32-bit apb slave decoding byte addresses paddr[7:0]
// Behaviour
// - quantum is two times (prescaler plus one) clocks
// - bit built from four whole-quantum segments
// - edge alignment segment is exactly one quantum
// - propagation segment programmable one to eight quanta
// - first phase one to eight, lengthened on resync
// - second phase two to eight, shortened on resync
// - single sample at phase one/two boundary
// - triple sample with majority, half-quantum spacing
// - programmed second phase never below two quanta
// - only recessive-to-dominant edges synchronize
// - hard sync restarts bit at alignment segment
// - edge outside alignment segment adjusts phase segments
// - each adjustment limited to jump width, one to four
`ifndef CAN_BIT_TIMING_MAP_SVH
`define CAN_BIT_TIMING_MAP_SVH

`define OFS_TIMING_CONFIG_FIRST  8'h00
`define OFS_TIMING_CONFIG_SECOND 8'h04
`define OFS_TIMING_CONFIG_THIRD  8'h08
`define OFS_ENGINE_CONTROL       8'h0C
`define OFS_ENGINE_STATUS        8'h10

// timing_config_first
`define POS_PRESCALER_LO 0
`define POS_PRESCALER_HI 5
`define POS_JUMP_LO      6
`define POS_JUMP_HI      7
// timing_config_second
`define POS_PROP_LO      0
`define POS_PROP_HI      2
`define POS_PHASE1_LO    3
`define POS_PHASE1_HI    5
`define POS_TRIPLE       6
// timing_config_third
`define POS_PHASE2_LO    0
`define POS_PHASE2_HI    2
// engine_control
`define POS_ENABLE       0

`define RST_TIMING_CONFIG_FIRST  8'h00
`define RST_TIMING_CONFIG_SECOND 8'h00
`define RST_TIMING_CONFIG_THIRD  8'h01
`define RST_ENGINE_CONTROL       8'h00

`define BIT_DECISION_DELAY_TQ    4'h2

`endif

// ### verilog/can_bit_timing_pkg.sv
// types shared by the bit-timing engine
// assumes the map header supplies all numeric constants
package can_bit_timing_pkg;

  typedef enum logic [1:0] {
    SEG_SYNC   = 2'b00,
    SEG_PROP   = 2'b01,
    SEG_PHASE1 = 2'b10,
    SEG_PHASE2 = 2'b11
  } seg_t;

endpackage

// ### verilog/can_bit_timing_engine.sv
// can bit-timing engine: quantum prescaler, segment sequencer, sampler and
// edge synchronisation, with its configuration behind an apb slave
// assumes rx_line is already synchronous to pclk (1 = recessive)
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "can_bit_timing_map.svh"

module can_bit_timing_engine (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_line,
  input  wire logic        hard_sync_allow,
  output logic             sampled_bit,
  output logic             sample_strobe
);

  // registers
  logic [7:0]                 timing_config_first_r;
  logic [7:0]                 timing_config_second_r;
  logic [7:0]                 timing_config_third_r;
  logic [7:0]                 engine_control_r;
  logic [31:0]                prdata_r;
  logic [6:0]                 presc_cnt_r;
  can_bit_timing_pkg::seg_t   seg_r;
  logic [3:0]                 q_cnt_r;
  logic [3:0]                 extend_r;
  logic [3:0]                 cut_r;
  logic                       restart_r;
  logic                       synced_r;
  logic                       rx_prev_r;
  logic                       early_s_r;
  logic                       mid_s_r;
  logic                       sampled_bit_r;
  logic                       sample_strobe_r;

  // decoded fields and combinational terms
  logic                       enable;
  logic                       triple;
  logic [5:0]                 rate_prescaler_field;
  logic [3:0]                 resync_jump_limit;
  logic [3:0]                 propagation_segment_length;
  logic [3:0]                 first_phase_segment_length;
  logic [3:0]                 second_phase_segment_length;
  logic [3:0]                 phase2_prog;
  logic [6:0]                 presc_last;
  logic [6:0]                 presc_half;
  logic                       tq_tick;
  logic                       fall_edge;
  logic                       hard_sync;
  logic                       resync;
  logic [3:0]                 phase1_eff;
  logic [3:0]                 phase2_eff;
  logic                       last_of_phase1;
  logic                       last_of_phase2;
  logic [3:0]                 late_err;
  logic [3:0]                 early_err;
  logic                       decided;
  logic                       apb_write;
  logic                       apb_read;
  logic                       addr_hit;

  // field value plus one, as a quantum count
  function automatic logic [3:0] seg_len(input logic [2:0] field);
    seg_len = {1'b0, field} + 4'h1;
  endfunction

  // phase error limited to the jump width
  function automatic logic [3:0] clip(input logic [3:0] err, input logic [3:0] lim);
    clip = (err > lim) ? lim : err;
  endfunction

  // two of three samples decide
  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  // ---------------- configuration fields ----------------
  assign enable               = engine_control_r[`POS_ENABLE];
  assign triple               = timing_config_second_r[`POS_TRIPLE];
  assign rate_prescaler_field = timing_config_first_r[`POS_PRESCALER_HI:`POS_PRESCALER_LO];
  assign resync_jump_limit    =
    {2'b00, timing_config_first_r[`POS_JUMP_HI:`POS_JUMP_LO]} + 4'h1;
  assign propagation_segment_length =
    seg_len(timing_config_second_r[`POS_PROP_HI:`POS_PROP_LO]);
  assign first_phase_segment_length =
    seg_len(timing_config_second_r[`POS_PHASE1_HI:`POS_PHASE1_LO]);
  assign phase2_prog =
    seg_len(timing_config_third_r[`POS_PHASE2_HI:`POS_PHASE2_LO]);
  // a programmed length of one is raised to the decision delay
  assign second_phase_segment_length =
    (phase2_prog < `BIT_DECISION_DELAY_TQ) ? `BIT_DECISION_DELAY_TQ : phase2_prog;

  // ---------------- apb slave ----------------
  assign apb_write = psel & penable & pwrite;
  assign apb_read  = psel & penable & ~pwrite;
  // five word registers, every other address refused
  assign addr_hit  = (paddr == `OFS_TIMING_CONFIG_FIRST)  |
                     (paddr == `OFS_TIMING_CONFIG_SECOND) |
                     (paddr == `OFS_TIMING_CONFIG_THIRD)  |
                     (paddr == `OFS_ENGINE_CONTROL)       |
                     (paddr == `OFS_ENGINE_STATUS);

  // every access completes without wait states
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = psel & penable & ~addr_hit;

  // configuration writes land in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_config_first_r  <= `RST_TIMING_CONFIG_FIRST;
      timing_config_second_r <= `RST_TIMING_CONFIG_SECOND;
      timing_config_third_r  <= `RST_TIMING_CONFIG_THIRD;
      engine_control_r       <= `RST_ENGINE_CONTROL;
    end else if (apb_write) begin
      unique case (paddr)
        `OFS_TIMING_CONFIG_FIRST:  timing_config_first_r  <= pwdata[7:0];
        `OFS_TIMING_CONFIG_SECOND: timing_config_second_r <= {1'b0, pwdata[6:0]};
        `OFS_TIMING_CONFIG_THIRD:  timing_config_third_r  <= {5'h00, pwdata[2:0]};
        `OFS_ENGINE_CONTROL:       engine_control_r       <= {7'h00, pwdata[0]};
        default: begin
        end
      endcase
    end
  end

  // read data is registered combinationally-addressed during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        `OFS_TIMING_CONFIG_FIRST:  prdata_r <= {24'h000000, timing_config_first_r};
        `OFS_TIMING_CONFIG_SECOND: prdata_r <= {24'h000000, timing_config_second_r};
        `OFS_TIMING_CONFIG_THIRD:  prdata_r <= {24'h000000, timing_config_third_r};
        `OFS_ENGINE_CONTROL:       prdata_r <= {24'h000000, engine_control_r};
        `OFS_ENGINE_STATUS:        prdata_r <= {16'h0000, cut_r, extend_r, q_cnt_r,
                                               seg_r, synced_r, sampled_bit_r};
        default:                   prdata_r <= 32'h0000_0000;
      endcase
    end else if (apb_read) begin
      prdata_r <= prdata_r;
    end
  end

  // ---------------- quantum prescaler ----------------
  assign presc_last = {rate_prescaler_field, 1'b1};
  // clock index half a quantum in
  assign presc_half = {1'b0, rate_prescaler_field} + 7'h01;
  assign tq_tick    = enable & (presc_cnt_r == presc_last);

  // ---------------- edge detection ----------------
  // only a falling line can synchronise
  assign fall_edge = enable & rx_prev_r & ~rx_line;
  assign hard_sync = fall_edge & hard_sync_allow;
  assign resync    = fall_edge & ~hard_sync_allow & ~synced_r &
                     (seg_r != can_bit_timing_pkg::SEG_SYNC);

  // previous line level, idle recessive after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rx_line;
    end
  end

  // quantum counter, restarted by hard sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_r <= 7'h00;
    end else if (!enable || hard_sync || tq_tick) begin
      presc_cnt_r <= 7'h00;
    end else begin
      presc_cnt_r <= presc_cnt_r + 7'h01;
    end
  end

  // ---------------- segment sequencer ----------------
  // effective phase lengths after resync
  assign phase1_eff     = first_phase_segment_length + extend_r;
  assign phase2_eff     = second_phase_segment_length - cut_r;
  assign last_of_phase1 = (seg_r == can_bit_timing_pkg::SEG_PHASE1) &
                          (q_cnt_r + 4'h1 >= phase1_eff);
  assign last_of_phase2 = (seg_r == can_bit_timing_pkg::SEG_PHASE2) &
                          (q_cnt_r + 4'h1 >= phase2_eff);

  // late: quanta elapsed since the alignment segment ended
  assign late_err  = (seg_r == can_bit_timing_pkg::SEG_PROP) ? q_cnt_r + 4'h1 :
                     propagation_segment_length + q_cnt_r + 4'h1;
  // early: quanta left before the next alignment segment
  assign early_err = second_phase_segment_length - q_cnt_r;

  // current segment and quantum index within it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_r   <= can_bit_timing_pkg::SEG_SYNC;
      q_cnt_r <= 4'h0;
    end else if (!enable || hard_sync) begin
      seg_r   <= can_bit_timing_pkg::SEG_SYNC;
      q_cnt_r <= 4'h0;
    end else if (tq_tick) begin
      unique case (seg_r)
        can_bit_timing_pkg::SEG_SYNC: begin
          seg_r   <= can_bit_timing_pkg::SEG_PROP;
          q_cnt_r <= 4'h0;
        end

        // propagation ends after its programmed quanta
        can_bit_timing_pkg::SEG_PROP: begin
          if (q_cnt_r + 4'h1 >= propagation_segment_length) begin
            seg_r   <= can_bit_timing_pkg::SEG_PHASE1;
            q_cnt_r <= 4'h0;
          end else begin
            q_cnt_r <= q_cnt_r + 4'h1;
          end
        end

        // decision falls in the last phase-one quantum
        can_bit_timing_pkg::SEG_PHASE1: begin
          if (last_of_phase1) begin
            seg_r   <= can_bit_timing_pkg::SEG_PHASE2;
            q_cnt_r <= 4'h0;
          end else begin
            q_cnt_r <= q_cnt_r + 4'h1;
          end
        end

        // phase two may be cut short by an early edge
        can_bit_timing_pkg::SEG_PHASE2: begin
          if (restart_r) begin
            // edge quantum served as alignment segment
            seg_r   <= can_bit_timing_pkg::SEG_PROP;
            q_cnt_r <= 4'h0;
          end else if (last_of_phase2) begin
            seg_r   <= can_bit_timing_pkg::SEG_SYNC;
            q_cnt_r <= 4'h0;
          end else begin
            q_cnt_r <= q_cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // ---------------- resynchronisation amounts ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extend_r <= 4'h0;
      cut_r    <= 4'h0;
    end else if (!enable || hard_sync ||
                 (tq_tick && seg_r == can_bit_timing_pkg::SEG_SYNC) ||
                 (tq_tick && restart_r)) begin
      extend_r <= 4'h0;
      cut_r    <= 4'h0;
    end else if (resync) begin
      if (seg_r == can_bit_timing_pkg::SEG_PHASE2) begin
        cut_r    <= clip(early_err, resync_jump_limit);
      end else begin
        extend_r <= clip(late_err, resync_jump_limit);
      end
    end
  end

  // early edge near the next bit: its quantum serves as alignment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_r <= 1'b0;
    end else if (!enable || hard_sync ||
                 (tq_tick && seg_r == can_bit_timing_pkg::SEG_SYNC) ||
                 (tq_tick && restart_r)) begin
      restart_r <= 1'b0;
    end else if (resync && seg_r == can_bit_timing_pkg::SEG_PHASE2) begin
      restart_r <= (early_err <= resync_jump_limit);
    end
  end

  // at most one resynchronisation between two sample points, none after a hard sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synced_r <= 1'b0;
    end else if (!enable) begin
      synced_r <= 1'b0;
    end else if (hard_sync || resync) begin
      synced_r <= 1'b1;
    end else if (decided) begin
      synced_r <= 1'b0;
    end
  end

  // ---------------- sampling ----------------
  assign decided = tq_tick & last_of_phase1;

  // first extra sample: opening clock of the last phase-one quantum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_s_r <= 1'b1;
    end else if (enable && last_of_phase1 && presc_cnt_r == 7'h00) begin
      early_s_r <= rx_line;
    end
  end

  // second extra sample: half a quantum later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mid_s_r <= 1'b1;
    end else if (enable && last_of_phase1 && presc_cnt_r == presc_half) begin
      mid_s_r <= rx_line;
    end
  end

  // strobe marks the cycle after the decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_strobe_r <= 1'b0;
    end else begin
      sample_strobe_r <= decided;
    end
  end

  // resolved level holds until the next decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_bit_r <= 1'b1;
    end else if (decided) begin
      sampled_bit_r <= triple ? majority(early_s_r, mid_s_r, rx_line) : rx_line;
    end
  end

  assign sampled_bit   = sampled_bit_r;
  assign sample_strobe = sample_strobe_r;

endmodule

// ### test/can_bus_node.sv
// far-side node model: drives the received line, recessive when idle
// assumes it is called right after a rising edge of pclk
`timescale 1ns/100ps
module can_bus_node (
  input  wire logic pclk,
  output logic      rx_line
);
  initial rx_line = 1'b1;
  // n bits msb first, per_clk cycles each, then back to recessive
  task automatic send(input logic [15:0] bits, input int n, input int per_clk);
    for (int i = n - 1; i >= 0; i--) begin
      rx_line <= bits[i];
      repeat (per_clk) @(posedge pclk);
    end
    rx_line <= 1'b1;
  endtask
endmodule

// ### test/can_bit_timing_sva.sv
// checker of the bit-timing engine ports: apb answers and bit strobes
// assumes it is bound to can_bit_timing_engine, one clock pclk
`timescale 1ns/100ps
module can_bit_timing_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_line,
  input wire logic        hard_sync_allow,
  input wire logic        sampled_bit,
  input wire logic        sample_strobe
);
  logic [7:0]  cfg1_r, cfg2_r, cfg3_r;
  logic [15:0] cnt_r;
  logic        rx_r, clean_r, wr, mapped;
  int          ph2, nominal_bit_period, per;

  assign wr     = psel && penable && pwrite && pready;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  assign ph2    = (cfg3_r[2:0] == 3'h0) ? 2 : int'(cfg3_r[2:0]) + 1;
  assign nominal_bit_period    = 3 + int'(cfg2_r[2:0]) + int'(cfg2_r[5:3]) + ph2;
  assign per    = 2 * (int'(cfg1_r[5:0]) + 1) * nominal_bit_period;

  // shadow of the timing fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_r <= 8'h00;
      cfg2_r <= 8'h00;
      cfg3_r <= 8'h01;
    end else if (wr) begin
      if (paddr == 8'h00) cfg1_r <= pwdata[7:0];
      if (paddr == 8'h04) cfg2_r <= pwdata[7:0];
      if (paddr == 8'h08) cfg3_r <= pwdata[7:0];
    end
  end

  // clean: no line change and no write since the previous strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_r    <= 1'b1;
      clean_r <= 1'b0;
      cnt_r   <= 16'h0000;
    end else begin
      rx_r  <= rx_line;
      cnt_r <= sample_strobe ? 16'h0000 : cnt_r + 16'h0001;
      if (wr || rx_line != rx_r) clean_r <= 1'b0;
      else if (sample_strobe) clean_r <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable;
  endsequence
  sequence s_quiet;
    !sample_strobe [*4];
  endsequence

  a_strobe_gap: assert property (sample_strobe |=> s_quiet)
    else $error("bit strobes too close");
  a_bit_holds: assert property (!sample_strobe |-> $stable(sampled_bit))
    else $error("bit changed without strobe");
  a_reset_bit: assert property ($rose(presetn) |-> sampled_bit && !sample_strobe)
    else $error("wrong bit outputs after reset");
  a_zero_wait: assert property (s_access |-> pready)
    else $error("access not answered at once");
  a_bad_addr: assert property (s_access ##0 !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_good_addr: assert property (!(psel && penable && !mapped) |-> !pslverr)
    else $error("error response without cause");
  a_bit_period: assert property (sample_strobe && clean_r |-> int'(cnt_r) == per - 1)
    else $error("bit period differs from settings");
  a_bit_value: assert property (sample_strobe && clean_r |-> sampled_bit == $past(rx_line))
    else $error("bit value differs from line");
endmodule

bind can_bit_timing_engine can_bit_timing_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_line(rx_line), .hard_sync_allow(hard_sync_allow), .sampled_bit(sampled_bit),
  .sample_strobe(sample_strobe)
);

// ### test/tb.sv
// self-checking bench of the bit-timing engine with a far-side node model
// assumes design, node model and checker compiled before it
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] pat = 16'h269A;
  logic        pclk, presetn, psel, penable, pwrite, hard_sync_allow, err;
  logic        pready, pslverr, rx_line, sampled_bit, sample_strobe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, tests_run;

  can_bit_timing_engine u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .hard_sync_allow(hard_sync_allow), .sampled_bit(sampled_bit),
    .sample_strobe(sample_strobe)
  );
  can_bus_node u_node (
    .pclk(pclk),
    .rx_line(rx_line)
  );

  always #20 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_regs;
    logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0000_0000);
      check("reset value", {31'h0, (i == 2) || (i == 4)}, rd);
    end
    apb(1'b1, 8'h00, 32'hFFFF_FFC5);
    apb(1'b0, 8'h00, 32'h0000_0000);
    check("readback", 32'h0000_00C5, rd);
    check("mapped error", 32'h0000_0000, {31'h0, err});
    apb(1'b1, 8'h14, 32'h0000_00FF);
    check("unmapped write error", 32'h0000_0001, {31'h0, err});
    apb(1'b0, 8'h14, 32'h0000_0000);
    check("unmapped read data", 32'h0000_0000, rd);
    $display("t_regs done");
  endtask

  // one frame of pat at per_clk cycles a bit, bits collected at strobes
  task automatic frame(input string what, input logic [7:0] c1, c2, c3, input int per_clk);
    logic [15:0] got;
    got = 16'h0000;
    apb(1'b1, 8'h00, {24'h0, c1});
    apb(1'b1, 8'h04, {24'h0, c2});
    apb(1'b1, 8'h08, {24'h0, c3});
    hard_sync_allow <= 1'b1;
    apb(1'b1, 8'h0C, 32'h0000_0001);
    fork
      u_node.send(pat, 16, per_clk);
      for (int i = 15; i >= 0; i--) begin
        do @(posedge pclk); while (sample_strobe !== 1'b1);
        got[i] = sampled_bit;
        hard_sync_allow <= 1'b0;
      end
    join
    check(what, {16'h0, pat}, {16'h0, got});
    apb(1'b1, 8'h0C, 32'h0000_0000);
    $display("%s done", what);
  endtask

  task automatic t_exact;
    frame("minimal bit", 8'h00, 8'h00, 8'h01, 10);
  endtask
  task automatic t_triple;
    frame("triple sample", 8'h41, 8'h4A, 8'h02, 36);
  endtask
  task automatic t_late;
    frame("late edges", 8'h41, 8'h0A, 8'h02, 38);
  endtask
  task automatic t_early;
    frame("early edges", 8'h41, 8'h0A, 8'h02, 34);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    pclk            = 1'b0;
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 8'h00;
    pwdata          = 32'h0000_0000;
    hard_sync_allow = 1'b1;
    n_mismatch      = 0;
    tests_run       = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_exact();
    t_triple();
    t_late();
    t_early();
    report_and_stop();
  end

  // tests need about 2000 cycles; allow 20000
  initial begin
    #800000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
